// file: rtl/gig_ms_regs.svh
// Purpose: Offsets, field positions, reset values of the role/next-page regs
// Assumes: Registers indexed by word; byte address is four times the index
// Notes:   Included by the register bank
`ifndef GIG_MS_REGS_SVH
`define GIG_MS_REGS_SVH

`define NP_RX_IDX         4'h8
`define ROLE_CTL_IDX      4'h9
`define ROLE_STS_IDX      4'ha
`define EXP_IDX           4'h6
`define SWCTL_IDX         4'hb

`define CTL_TEST_HI       15
`define CTL_TEST_LO       13
`define CTL_MAN_EN        12
`define CTL_MAN_VAL       11
`define CTL_PORT_TYPE     10
`define CTL_ADV_FD        9
`define CTL_ADV_HD        8

`define STS_FAULT         15
`define STS_MASTER        14
`define STS_LOC_RX        13
`define STS_REM_RX        12
`define STS_LP_FD         11
`define STS_LP_HD         10

`define EXP_PAGE_RX       1

`define CTL_RW_MASK       16'hff00
`define NP_RX_RESET       16'h2000
`define IDLE_CNT_MAX      8'hff
`define IDLE_CNT_RESET    8'h00

`define SWCTL_SOFT_RST    0
`define SWCTL_LOGIC_RST   1

`endif

// file: rtl/gig_ms_pkg.sv
// Purpose: Types for the gigabit role/next-page register bank
// Assumes: Constants live in gig_ms_regs.svh
// Notes:   Only types here
package gig_ms_pkg;

  typedef enum logic [2:0] {
    TEST_NORMAL     = 3'h0,
    TEST_WAVEFORM   = 3'h1,
    TEST_JIT_MASTER = 3'h2,
    TEST_JIT_SLAVE  = 3'h3,
    TEST_DISTORT    = 3'h4
  } test_mode_e;

  typedef struct packed {
    logic nextPage;
    logic ack;
    logic messagePage;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } next_page_s;

  typedef struct packed {
    logic msFault;
    logic resolvedMaster;
    logic localRxOk;
    logic remoteRxOk;
    logic partner_gig_full_ability;
    logic partner_gig_half_ability;
    logic idleError;
  } line_status_s;

  typedef struct packed {
    logic       manualEnable;
    logic       forceMaster;
    logic       multiPort;
    logic       advFull;
    logic       advHalf;
    test_mode_e testMode;
    logic [1:0] testSel;
  } role_ctl_s;

endpackage

// file: rtl/gig_ms_regbank.sv
// Purpose: APB register bank for received next page and gigabit role regs
// Assumes: One 20 MHz clock; line-side inputs synchronous to it
// Notes:   Zero-wait APB slave, pslverr on unmapped addresses
// Notes:   Read data is captured in the setup cycle; read side effects
//          (latch clear, count clear) happen in the access cycle
// Notes:   Control bits 12..8 come from the straps after hardware and soft reset
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gig_ms_regs.svh"

//Contract
// RQ1 - Test code 000 normal, 001 waveform
// RQ2 - 010 jitter master, 011 slave, 100 distortion
// RQ3 - Software avoids test modes giving two masters
// RQ4 - Bit 12 enables manual role choice
// RQ5 - Bit 11 forces master or slave manually
// RQ6 - Bit 10 port type only when automatic
// RQ7 - Bits 9,8 advertise gigabit full/half duplex
// RQ8 - Control bits 12..8 reset from straps
// RQ9 - Status 15 latches role configuration fault
// RQ10 - Status 14 shows resolved master role
// RQ11 - Status 13 shows local receiver OK
// RQ12 - Status 12 shows remote receiver OK
// RQ13 - Status 11,10 partner gigabit abilities
// RQ14 - Status 7..0 count idle errors
// RQ15 - Counter clears on read and resets
// RQ16 - Counter saturates at all ones
// RQ17 - Counter overflow flags an interrupt source
// RQ18 - Next page read-only, flags 15,14
// RQ19 - Page bit 13 message, 12 comply
// RQ20 - Page bit 11 carries toggle
// RQ21 - Page bits 10..0 code, reset zero
// RQ22 - Page received latches until read
// RQ23 - Latched bits clear only on read; code also clears them on soft or logic reset
// RQ24 - Reserved bits read zero, ignore writes
module gig_ms_regbank #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Configuration straps
  input  wire logic [4:0]              strapRole,
  // Line side from negotiation engine
  input  wire logic                    pageValid,
  input  wire gig_ms_pkg::next_page_s  pageIn,
  input  wire gig_ms_pkg::line_status_s lineStatus,
  // Control to the rest of the PHY
  output gig_ms_pkg::role_ctl_s        roleCtl,
  output logic                         roleManual,
  output logic                         roleForceMaster,
  output logic                         idleOverflow,
  output logic                         logicResetOut
);

  // Word match on an aligned byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [3:0]        idx);
    logic [ADDR_W-3:0] w;
    w       = a[ADDR_W-1:2];
    reg_hit = (a[1:0] == 2'h0) && (w == (ADDR_W-2)'(idx));
  endfunction

  // Address decode
  wire logic              setup    = psel & ~penable;
  wire logic              access   = psel & penable;
  wire logic              hitNp    = reg_hit(paddr, `NP_RX_IDX);
  wire logic              hitCtl   = reg_hit(paddr, `ROLE_CTL_IDX);
  wire logic              hitSts   = reg_hit(paddr, `ROLE_STS_IDX);
  wire logic              hitExp   = reg_hit(paddr, `EXP_IDX);
  wire logic              hitSw    = reg_hit(paddr, `SWCTL_IDX);
  wire logic              mapped   = hitNp | hitCtl | hitSts | hitExp | hitSw;
  wire logic              wrCtl    = access & pwrite & hitCtl;
  wire logic              wrSw     = access & pwrite & hitSw;
  wire logic              rdSts    = access & ~pwrite & hitSts;
  wire logic              rdExp    = access & ~pwrite & hitExp;

  // Registers
  logic [15:0] ctl_reg;
  wire logic [15:0] ctl_next;
  logic [15:0] np_reg;
  logic        fault_reg;
  logic        pageRx_reg;
  logic [7:0]  idle_reg;
  logic [7:0]  idle_next;
  logic        softRst_reg;
  logic        logicRst_reg;
  logic        strapLoad_reg;
  logic        ovf_reg;
  logic [31:0] rdata_reg;
  logic        err_reg;

  // Software or logic reset clears the count and page state
  wire logic localClr = softRst_reg | logicRst_reg;

  // Per-bit write merge; reserved control bits keep their zero
  localparam logic [15:0] CTL_MASK = `CTL_RW_MASK;
  genvar bi;
  generate
    for (bi = 0; bi < 16; bi++) begin : g_ctl_bit
      if (CTL_MASK[bi]) begin : g_rw
        assign ctl_next[bi] = pwdata[bi];
      end else begin : g_ro
        assign ctl_next[bi] = ctl_reg[bi]; // RQ24
      end
    end
  endgenerate

  // Strap load flag: high for the first edge after reset

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapLoad_reg <= 1'b1;
    end else begin
      strapLoad_reg <= 1'b0;
    end
  end

  // Strap image of the role and ability bits
  wire logic   strapManEn  = strapRole[4];
  wire logic   strapManVal = strapRole[3];
  wire logic   strapPort   = strapRole[2];
  wire logic   strapAdvFd  = strapRole[1];
  wire logic   strapAdvHd  = strapRole[0];
  logic [15:0] strapWord;
  always_comb begin
    strapWord                 = 16'h0000;
    strapWord[`CTL_MAN_EN]    = strapManEn;
    strapWord[`CTL_MAN_VAL]   = strapManVal;
    strapWord[`CTL_PORT_TYPE] = strapPort;
    strapWord[`CTL_ADV_FD]    = strapAdvFd;
    strapWord[`CTL_ADV_HD]    = strapAdvHd;
  end

  // Control register: straps after reset, then software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= 16'h0000;
    end else if (strapLoad_reg || softRst_reg) begin
      ctl_reg <= strapWord; // RQ8
    end else if (wrCtl) begin
      ctl_reg <= ctl_next; // RQ24
    end
  end

  // Reset control writes
  wire logic swSoft  = wrSw & pwdata[`SWCTL_SOFT_RST];
  wire logic swLogic = pwdata[`SWCTL_LOGIC_RST];

  // Soft reset is a one-cycle strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softRst_reg <= 1'b0;
    end else begin
      softRst_reg <= swSoft;
    end
  end

  // Logic reset is a level kept until software lowers it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      logicRst_reg <= 1'b0;
    end else if (wrSw) begin
      logicRst_reg <= swLogic;
    end
  end

  // Field view of an arriving page
  wire logic        pgNext   = pageIn.nextPage;    // RQ18
  wire logic        pgAck    = pageIn.ack;         // RQ18
  wire logic        pgMsg    = pageIn.messagePage; // RQ19
  wire logic        pgAck2   = pageIn.ack2;        // RQ19
  wire logic        pgToggle = pageIn.toggle;      // RQ20
  wire logic [10:0] pgCode   = pageIn.code;        // RQ21
  wire logic [15:0] pageWord = {pgNext, pgAck, pgMsg, pgAck2, pgToggle,
                                pgCode};

  // Received page capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      np_reg <= `NP_RX_RESET; // RQ21
    end else if (localClr) begin
      np_reg <= `NP_RX_RESET;
    end else if (pageValid) begin
      np_reg <= pageWord; // RQ18 RQ19 RQ20 RQ21
    end
  end

  // Latch-high flags: bit 0 page received, bit 1 role fault
  localparam int NLATCH = 2;
  wire logic [NLATCH-1:0] latchSet = {lineStatus.msFault, pageValid};
  wire logic [NLATCH-1:0] latchClr = {rdSts, rdExp};
  wire logic [NLATCH-1:0] latchQ;

  // Set beats the read clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NLATCH; gi++) begin : g_latch
      logic flag_reg;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_reg <= 1'b0;
        end else if (localClr) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= latchSet[gi] | (flag_reg & ~latchClr[gi]); // RQ23
        end
      end
      assign latchQ[gi] = flag_reg;
    end
  endgenerate

  assign pageRx_reg = latchQ[0]; // RQ22
  assign fault_reg  = latchQ[1]; // RQ9

  // Idle error counter
  wire logic cntFull = (idle_reg == `IDLE_CNT_MAX);
  wire logic cntInc  = lineStatus.idleError & ~cntFull; // RQ16
  always_comb begin
    idle_next = idle_reg;
    if (rdSts) begin
      idle_next = lineStatus.idleError ? 8'h01 : `IDLE_CNT_RESET; // RQ15
    end else if (cntInc) begin
      idle_next = idle_reg + 8'h01; // RQ14
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_reg <= `IDLE_CNT_RESET;
    end else if (localClr) begin
      idle_reg <= `IDLE_CNT_RESET; // RQ15
    end else begin
      idle_reg <= idle_next;
    end
  end

  // Overflow pulse for the interrupt logic
  wire logic ovfHit = cntFull & lineStatus.idleError & ~rdSts;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_reg <= 1'b0;
    end else if (localClr) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovfHit; // RQ17
    end
  end

  // Read mux
  wire logic stsFault  = fault_reg;                            // RQ9
  wire logic stsMaster = lineStatus.resolvedMaster;            // RQ10
  wire logic stsLocRx  = lineStatus.localRxOk;                 // RQ11
  wire logic stsRemRx  = lineStatus.remoteRxOk;                // RQ12
  wire logic stsLpFd   = lineStatus.partner_gig_full_ability;  // RQ13
  wire logic stsLpHd   = lineStatus.partner_gig_half_ability;  // RQ13
  wire logic [15:0] stsWord = {stsFault, stsMaster, stsLocRx, stsRemRx,
                               stsLpFd, stsLpHd, 2'h0, idle_reg}; // RQ24

  // Expansion and reset-control views
  logic [15:0] expWord;
  logic [15:0] swWord;
  always_comb begin
    expWord                  = 16'h0000;
    expWord[`EXP_PAGE_RX]    = pageRx_reg;
    swWord                   = 16'h0000;
    swWord[`SWCTL_LOGIC_RST] = logicRst_reg;
  end

  // Word select; unmapped reads give zero
  logic [15:0] rdWord;
  always_comb begin
    rdWord = 16'h0000;
    case (1'b1)
      hitNp:   rdWord = np_reg;
      hitCtl:  rdWord = ctl_reg;
      hitSts:  rdWord = stsWord;
      hitExp:  rdWord = expWord;
      hitSw:   rdWord = swWord;
      default: rdWord = 16'h0000; // RQ24
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      rdata_reg <= {16'h0000, rdWord};
    end
  end

  // Error flag captured with the address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_reg <= 1'b0;
    end else if (setup) begin
      err_reg <= ~mapped;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = access & err_reg;

  // Role and test controls
  function automatic gig_ms_pkg::test_mode_e decode_test(input logic [2:0] c);
    case (c)
      3'h1:    decode_test = gig_ms_pkg::TEST_WAVEFORM;   // RQ1
      3'h2:    decode_test = gig_ms_pkg::TEST_JIT_MASTER; // RQ2
      3'h3:    decode_test = gig_ms_pkg::TEST_JIT_SLAVE;
      3'h4:    decode_test = gig_ms_pkg::TEST_DISTORT;
      default: decode_test = gig_ms_pkg::TEST_NORMAL;     // RQ1 RQ2
    endcase
  endfunction

  // Control fields
  wire logic [2:0] ctlTest   = ctl_reg[`CTL_TEST_HI:`CTL_TEST_LO];
  wire logic       manEn     = ctl_reg[`CTL_MAN_EN];
  wire logic       ctlManVal = ctl_reg[`CTL_MAN_VAL];
  wire logic       ctlPort   = ctl_reg[`CTL_PORT_TYPE];
  wire logic       ctlAdvFd  = ctl_reg[`CTL_ADV_FD];
  wire logic       ctlAdvHd  = ctl_reg[`CTL_ADV_HD];

  // Manual value counts only when manual mode is on
  wire logic       forceMst  = manEn & ctlManVal;

  assign roleCtl.manualEnable = manEn;                   // RQ4
  assign roleCtl.forceMaster  = forceMst;                // RQ5
  assign roleCtl.multiPort    = ~manEn & ctlPort;        // RQ6
  assign roleCtl.advFull      = ctlAdvFd;                // RQ7
  assign roleCtl.advHalf      = ctlAdvHd;                // RQ7
  assign roleCtl.testMode     = decode_test(ctlTest);
  assign roleCtl.testSel      = 2'h0;
  assign roleManual           = manEn;
  assign roleForceMaster      = forceMst;
  assign idleOverflow         = ovf_reg;
  assign logicResetOut        = logicRst_reg;

endmodule // gig_ms_regbank

`default_nettype wire

// file: dv/gig_ms_line_model.sv
// Purpose: Line-side stand-in: page pulses, status, idle errors
// Assumes: Driven just after rising edges
// Notes:   Page bus shows inverted data once its pulse is over
`timescale 1ns/1ps
`default_nettype none
module gig_ms_line_model (
  // Clock
  input  wire logic                    clk,
  // Line side
  output var logic                     pageValid,
  output var gig_ms_pkg::next_page_s   pageIn,
  output var gig_ms_pkg::line_status_s lineStatus
);
  initial begin
    pageValid = 1'b0;
    pageIn = '0;
    lineStatus = '0;
  end
  task automatic page(input logic [15:0] v);
    @(posedge clk);
    pageIn <= v;
    pageValid <= 1'b1;
    @(posedge clk);
    pageValid <= 1'b0;
    pageIn <= ~v;
  endtask
  task automatic stat(input logic [6:0] v);
    @(posedge clk);
    lineStatus <= v;
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge clk);
      lineStatus.idleError <= 1'b1;
    end
    @(posedge clk);
    lineStatus.idleError <= 1'b0;
  endtask
endmodule // gig_ms_line_model
`default_nettype wire

// file: dv/gig_ms_regbank_sva.sv
// Purpose: Port checks on the role/next-page register bank
// Assumes: Zero-wait APB; straps load on first edge after reset
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module gig_ms_regbank_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  input wire logic [4:0]               strapRole,
  input wire gig_ms_pkg::line_status_s lineStatus,
  input wire gig_ms_pkg::role_ctl_s    roleCtl,
  input wire logic                     roleManual,
  input wire logic                     roleForceMaster,
  input wire logic                     idleOverflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire acc = psel & penable;
  wire rdAcc = acc & ~pwrite;
  wire isCtl = paddr == ADDR_W'(12'h24);
  wire ctlWr = acc & pwrite & isCtl;
  wire unmap = !(paddr inside {12'h18, 12'h20, 12'h24, 12'h28, 12'h2c});
  a_strap_load: assert property ($rose(rstn) |=>
    roleCtl.manualEnable == $past(strapRole[4]) &&
    roleCtl.forceMaster == $past(strapRole[4] & strapRole[3]) &&
    roleCtl.multiPort == $past(!strapRole[4] & strapRole[2]) &&
    roleCtl.advFull == $past(strapRole[1]) &&
    roleCtl.advHalf == $past(strapRole[0])) else $error("strap load");
  a_ctl_write: assert property (ctlWr |=>
    roleCtl.manualEnable == $past(pwdata[12]) &&
    roleCtl.forceMaster == $past(pwdata[12] & pwdata[11]) &&
    roleCtl.multiPort == $past(!pwdata[12] & pwdata[10]) &&
    roleCtl.advFull == $past(pwdata[9]) &&
    roleCtl.advHalf == $past(pwdata[8])) else $error("ctl write");
  a_test_code: assert property (ctlWr && pwdata[15:13] <= 3'h4 |=>
    roleCtl.testMode == $past(pwdata[15:13])) else $error("test code");
  a_test_rsvd: assert property (ctlWr && pwdata[15:13] > 3'h4 |=>
    roleCtl.testMode == 3'h0) else $error("reserved test code");
  a_role_copy: assert property (roleManual == roleCtl.manualEnable &&
    roleForceMaster == roleCtl.forceMaster) else $error("role copy");
  a_upper_zero: assert property (rdAcc |-> prdata[31:16] == 16'h0)
    else $error("upper half");
  a_ctl_rsvd: assert property (rdAcc && isCtl |-> prdata[7:0] == 8'h0)
    else $error("ctl reserved");
  a_unmapped_err: assert property (acc && unmap |-> pslverr &&
    prdata == 32'h0) else $error("unmapped");
  a_ovf_cause: assert property (idleOverflow |->
    $past(lineStatus.idleError)) else $error("overflow cause");
endmodule // gig_ms_regbank_sva
bind gig_ms_regbank gig_ms_regbank_sva #(.ADDR_W(ADDR_W)) chk (.clk, .rstn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .strapRole,
  .lineStatus, .roleCtl, .roleManual, .roleForceMaster, .idleOverflow);
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the role/next-page register bank
// Assumes: 20 MHz clock, APB master tasks below
// Notes:   Straps at 5'h15 until t_role sets 5'h0a
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, er, sawOvf;
  logic pageValid, idleOverflow, roleManual, roleForceMaster, logicRst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  strapRole;
  gig_ms_pkg::next_page_s   pageIn;
  gig_ms_pkg::line_status_s lineStatus;
  gig_ms_pkg::role_ctl_s    roleCtl;
  int error_cnt, n_checks;
  wire logic [2:0] roleV = {roleManual, roleForceMaster, roleCtl.multiPort};
  gig_ms_regbank DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .strapRole, .pageValid, .pageIn, .lineStatus,
    .roleCtl, .roleManual, .roleForceMaster, .idleOverflow,
    .logicResetOut(logicRst));
  gig_ms_line_model line (.clk, .pageValid, .pageIn, .lineStatus);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (idleOverflow === 1'b1) sawOvf <= 1'b1;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_ctl;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h24, {c[2:0], 13'h0aff});
      #1 chk("mode", c < 5 ? c : 0, 32'(roleCtl.testMode));
      apb(1'b0, 12'h24, 16'h0);
      if (c < 5) chk("ctl", {c[2:0], 13'h0a00}, rd);
    end
    apb(1'b1, 12'h30, 16'hffff);
    chk("werr", 1, er);
    apb(1'b0, 12'h26, 16'h0);
    chk("rerr", 1, er);
  endtask
  task automatic t_page;
    line.page(16'hd9a5);
    apb(1'b0, 12'h18, 16'h0);
    chk("pgrx", 2, rd);
    apb(1'b0, 12'h18, 16'h0);
    chk("pgclr", 0, rd);
    apb(1'b1, 12'h20, 16'h1234);
    apb(1'b0, 12'h20, 16'h0);
    chk("np", 32'hd9a5, rd);
  endtask
  task automatic rd_sts(input string nm, input logic [31:0] e);
    apb(1'b0, 12'h28, 16'h0);
    chk(nm, e, rd);
  endtask
  task automatic t_status;
    line.stat(7'h54);
    line.stat(7'h2a);
    rd_sts("stsA", 32'hd400);
    rd_sts("stsB", 32'h5400);
    line.stat(7'h0);
    line.errs(5);
    rd_sts("cnt", 5);
    rd_sts("cntclr", 0);
    line.errs(260);
    rd_sts("sat", 32'hff);
    chk("ovf", 1, sawOvf);
  endtask
  task automatic t_resets;
    line.errs(3);
    apb(1'b1, 12'h24, 16'h0);
    apb(1'b1, 12'h2c, 16'h1);
    apb(1'b1, 12'h2c, 16'h0);
    rd_sts("soft", 0);
    apb(1'b0, 12'h24, 16'h0);
    chk("strap", 32'h1500, rd);
    line.errs(4);
    apb(1'b1, 12'h2c, 16'h2);
    #1 chk("lrst", 1, logicRst);
    apb(1'b1, 12'h2c, 16'h0);
    rd_sts("logic", 0);
  endtask
  task automatic t_role;
    @(posedge clk);
    rstn <= 1'b0;
    strapRole <= 5'h0a;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h24, 16'h0);
    chk("strap2", 32'h0a00, rd);
    chk("adv", 2, {roleCtl.advFull, roleCtl.advHalf});
    chk("noforce", 0, roleV);
    chk("rdy", 1, pready);
    apb(1'b1, 12'h24, 16'h1c00);
    #1 chk("man", 6, roleV);
    apb(1'b1, 12'h24, 16'h0400);
    #1 chk("auto", 1, roleV);
  endtask
  initial begin
    {rstn, psel, penable, pwrite, sawOvf} = '0;
    {paddr, pwdata, error_cnt, n_checks} = '0;
    strapRole = 5'h15;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h24, 16'h0);
    chk("ctl0", 32'h1500, rd);
    apb(1'b0, 12'h20, 16'h0);
    chk("np0", 32'h2000, rd);
    rd_sts("sts0", 0);
    t_ctl();
    t_page();
    t_status();
    t_resets();
    t_role();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
